// ---- rtl/diag_flags_pkg.sv ----
package diag_flags_pkg;

    // register addresses on the serial interface
    localparam logic [4:0] DIAG_RESULTS_ADDR = 5'h14;
    localparam logic [4:0] READBACK_SEL_ADDR = 5'h13;
    // addresses that decode to a register, one bit per address
    localparam logic [31:0] VALID_ADDR_MASK = 32'h11FF_9FFF;
    // addresses whose register is read only
    localparam logic [31:0] READ_ONLY_MASK = 32'h11C0_0000;

    // full readback word after reset, address echo included
    localparam logic [23:0] RESULTS_RESET = 24'h14_A000;
    localparam logic [9:0] FLAGS_RESET = 10'h000;
    // bits that hold a flag; bits 7 and 3 are reserved
    localparam logic [9:0] FLAG_IMPL_MASK = 10'h377;

    // flag positions
    localparam int INTERDIE_BIT = 9;
    localparam int LATCH_BIT = 8;
    localparam int INVERSE_BIT = 6;
    localparam int CALCRC_BIT = 5;
    localparam int ACCESS_BIT = 4;
    localparam int COUNT_BIT = 2;
    localparam int SLIP_BIT = 1;
    localparam int SPICRC_BIT = 0;

    // serial word fields
    localparam int WORD_SLIP_POS = 23;
    localparam int WORD_READ_POS = 22;
    localparam int WORD_ADDR_LSB = 16;

    // legal falling-edge counts per frame, and the count at which the edge counter saturates
    localparam logic [5:0] SHORT_FRAME_EDGES = 6'h18;
    localparam logic [5:0] LONG_FRAME_EDGES = 6'h20;
    localparam logic [5:0] EDGE_COUNT_MAX = 6'h3F;

    // crc-8, polynomial x^8 + x^2 + x + 1
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // one bit step of the crc, msb first
    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic din);
        logic fb;
        fb = crc[7] ^ din;
        crc8_step = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    endfunction : crc8_step

endpackage : diag_flags_pkg

// ---- rtl/serial_frame_rx.sv ----
`timescale 1ns/1ps
// samples the serial pins, counts edges and checks each frame at chip select release
module serial_frame_rx (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // serial pins and crc enable
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdi_i,
    input wire logic crc_enable_i,
    // frame results
    output logic frame_start_o,
    output logic fall_edge_o,
    output logic frame_done_o,
    output logic [23:0] word_o,
    output logic count_err_o,
    output logic slip_err_o,
    output logic crc_err_o
);

    logic [2:0] sclk_sync_reg;
    logic [2:0] sync_sync_reg;
    logic [2:0] sdi_sync_reg;
    logic [31:0] shift_reg;
    logic [5:0] count_reg;
    logic [7:0] crc_calc;
    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;
    logic long_frame;
    logic short_frame;
    logic [23:0] word_sel;

    // three-stage synchronisers; only stages two and three are compared
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_sync_reg <= 3'h0;
            sync_sync_reg <= 3'h7;
            sdi_sync_reg <= 3'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
            sync_sync_reg <= {sync_sync_reg[1:0], sync_n_i};
            sdi_sync_reg <= {sdi_sync_reg[1:0], sdi_i};
        end
    end

    // edge detection on the agreed stages
    assign sclk_fall = sclk_sync_reg[2] & ~sclk_sync_reg[1];
    assign sync_fall = sync_sync_reg[2] & ~sync_sync_reg[1];
    assign sync_rise = ~sync_sync_reg[2] & sync_sync_reg[1];

    // shift in data and count falling edges while selected
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_reg <= 32'h0000_0000;
            count_reg <= 6'h00;
        end else if (sync_fall) begin
            count_reg <= 6'h00;
        end else if (!sync_sync_reg[2] && sclk_fall) begin
            shift_reg <= {shift_reg[30:0], sdi_sync_reg[2]};
            count_reg <= (count_reg == diag_flags_pkg::EDGE_COUNT_MAX) ? count_reg : count_reg + 6'h01;
        end
    end

    // a long frame carries the word followed by its crc byte
    assign long_frame = (count_reg == diag_flags_pkg::LONG_FRAME_EDGES);
    assign short_frame = (count_reg == diag_flags_pkg::SHORT_FRAME_EDGES);
    assign word_sel = long_frame ? shift_reg[31:8] : shift_reg[23:0];

    always_comb begin
        crc_calc = diag_flags_pkg::CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            crc_calc = diag_flags_pkg::crc8_step(crc_calc, word_sel[i]);
        end
    end

    // checks complete at chip select release
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_start_o <= 1'b0;
            fall_edge_o <= 1'b0;
            frame_done_o <= 1'b0;
            word_o <= 24'h00_0000;
            count_err_o <= 1'b0;
            slip_err_o <= 1'b0;
            crc_err_o <= 1'b0;
        end else begin
            frame_start_o <= sync_fall;
            fall_edge_o <= !sync_sync_reg[2] && sclk_fall;
            frame_done_o <= sync_rise;
            word_o <= word_sel;
            count_err_o <= sync_rise && (crc_enable_i ? !long_frame : !(long_frame || short_frame));
            slip_err_o <= sync_rise && (long_frame || short_frame) &&
                (word_sel[diag_flags_pkg::WORD_SLIP_POS] == word_sel[diag_flags_pkg::WORD_READ_POS]);
            crc_err_o <= sync_rise && crc_enable_i && long_frame && (crc_calc != shift_reg[7:0]);
        end
    end

endmodule : serial_frame_rx

// ---- rtl/cal_mem_crc_check.sv ----
`timescale 1ns/1ps
// tracks calibration memory refresh and checks its crc over the streamed words
module cal_mem_crc_check (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // refresh stream
    input wire logic refresh_start_i,
    input wire logic cal_word_valid_i,
    input wire logic [15:0] cal_word_i,
    input wire logic refresh_done_i,
    input wire logic [7:0] cal_crc_i,
    // status
    output logic refresh_busy_o,
    output logic unrefreshed_o,
    output logic crc_fail_o
);

    logic [7:0] crc_reg;
    logic [7:0] crc_next;

    // fold one 16-bit word into the running crc
    always_comb begin
        crc_next = crc_reg;
        for (int i = 15; i >= 0; i--) begin
            crc_next = diag_flags_pkg::crc8_step(crc_next, cal_word_i[i]);
        end
    end

    // unrefreshed from reset, and again from each refresh start, until that refresh finishes
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            crc_reg <= diag_flags_pkg::CRC_INIT;
            refresh_busy_o <= 1'b0;
            unrefreshed_o <= 1'b1;
            crc_fail_o <= 1'b0;
        end else begin
            crc_fail_o <= 1'b0;
            if (refresh_start_i) begin
                crc_reg <= diag_flags_pkg::CRC_INIT;
                refresh_busy_o <= 1'b1;
                unrefreshed_o <= 1'b1;
            end else if (refresh_busy_o && cal_word_valid_i) begin
                crc_reg <= crc_next;
            end else if (refresh_busy_o && refresh_done_i) begin
                refresh_busy_o <= 1'b0;
                unrefreshed_o <= 1'b0;
                crc_fail_o <= (crc_reg != cal_crc_i);
            end
        end
    end

endmodule : cal_mem_crc_check

// ---- rtl/digital_diag_error_flags.sv ----
`timescale 1ns/1ps
module digital_diag_error_flags (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // serial interface pins
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    // diagnostic setup, one enable per flag, and serial crc enable
    input wire logic [9:0] diag_enable_i,
    input wire logic crc_enable_i,
    // upper readback bits owned by neighbouring logic
    input wire logic fault_pin_status_i,
    input wire logic slew_busy_i,
    input wire logic [2:0] upper_flags_i,
    // inter-die compare and dac monitors
    input wire logic interdie_parity_err_i,
    input wire logic [15:0] latch_in_i,
    input wire logic [15:0] latch_out_i,
    input wire logic dac_code_load_i,
    input wire logic [15:0] dac_code_i,
    // calibration memory refresh stream
    input wire logic refresh_start_i,
    input wire logic cal_word_valid_i,
    input wire logic [15:0] cal_word_i,
    input wire logic refresh_done_i,
    input wire logic [7:0] cal_crc_i,
    // flag state and accepted register writes
    output logic [9:0] flags_o,
    output logic write_strobe_o,
    output logic [4:0] write_addr_o,
    output logic [15:0] write_data_o
);

    logic frame_start;
    logic fall_edge;
    logic frame_done;
    logic [23:0] frame_word;
    logic count_err;
    logic slip_err;
    logic crc_err;
    logic refresh_busy;
    logic unrefreshed;
    logic cal_fail;

    logic [9:0] flags_reg;
    logic [9:0] flags_next;
    logic [9:0] flag_set;
    logic [9:0] flag_clr;
    logic [15:0] inv_copy_reg;
    logic [4:0] readback_addr_reg;
    logic [23:0] sdo_shift_reg;
    logic [23:0] readback_word;
    logic [23:0] results_word;

    logic frame_ok;
    logic is_read;
    logic [4:0] addr;
    logic [15:0] data;
    logic addr_invalid;
    logic addr_read_only;
    logic write_blocked;
    logic access_err;
    logic write_ok;
    logic clear_write;
    logic readback_write;
    logic latch_mismatch;
    logic inverse_fault;

    // frame receiver and checks
    serial_frame_rx u_rx (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .sclk_i(sclk_i),
        .sync_n_i(sync_n_i),
        .sdi_i(sdi_i),
        .crc_enable_i(crc_enable_i),
        .frame_start_o(frame_start),
        .fall_edge_o(fall_edge),
        .frame_done_o(frame_done),
        .word_o(frame_word),
        .count_err_o(count_err),
        .slip_err_o(slip_err),
        .crc_err_o(crc_err)
    );

    // calibration memory refresh tracking
    cal_mem_crc_check u_cal (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .refresh_start_i(refresh_start_i),
        .cal_word_valid_i(cal_word_valid_i),
        .cal_word_i(cal_word_i),
        .refresh_done_i(refresh_done_i),
        .cal_crc_i(cal_crc_i),
        .refresh_busy_o(refresh_busy),
        .unrefreshed_o(unrefreshed),
        .crc_fail_o(cal_fail)
    );

    // frame decode; a frame that failed any check is discarded
    assign frame_ok = frame_done && !count_err && !slip_err && !crc_err;
    assign is_read = frame_word[diag_flags_pkg::WORD_READ_POS];
    assign addr = frame_word[diag_flags_pkg::WORD_ADDR_LSB +: 5];
    assign data = frame_word[15:0];

    assign addr_invalid = !diag_flags_pkg::VALID_ADDR_MASK[addr];
    assign addr_read_only = !is_read && diag_flags_pkg::READ_ONLY_MASK[addr];
    assign write_blocked = !is_read && (unrefreshed || refresh_busy) &&
        (addr != diag_flags_pkg::READBACK_SEL_ADDR);
    assign access_err = frame_ok && (addr_invalid || addr_read_only || write_blocked);
    assign write_ok = frame_ok && !is_read && !addr_invalid && !addr_read_only && !write_blocked;
    assign clear_write = write_ok && (addr == diag_flags_pkg::DIAG_RESULTS_ADDR);
    assign readback_write = write_ok && (addr == diag_flags_pkg::READBACK_SEL_ADDR);

    assign latch_mismatch = (latch_in_i != latch_out_i);
    // core code against inverted copy; skipped while the copy reloads
    assign inverse_fault = !dac_code_load_i && (dac_code_i != ~inv_copy_reg);

    // raw event vector, one term per flag position
    always_comb begin
        flag_set = 10'h000;
        flag_set[diag_flags_pkg::INTERDIE_BIT] = interdie_parity_err_i;
        flag_set[diag_flags_pkg::LATCH_BIT] = latch_mismatch;
        flag_set[diag_flags_pkg::INVERSE_BIT] = inverse_fault;
        flag_set[diag_flags_pkg::CALCRC_BIT] = cal_fail;
        flag_set[diag_flags_pkg::ACCESS_BIT] = access_err;
        flag_set[diag_flags_pkg::COUNT_BIT] = count_err;
        flag_set[diag_flags_pkg::SLIP_BIT] = slip_err;
        flag_set[diag_flags_pkg::SPICRC_BIT] = crc_err;
    end

    // write one clears, set beats clear
    assign flag_clr = clear_write ? data[9:0] : 10'h000;
    // disabled flags neither set nor read
    // reserved bits never hold a one
    assign flags_next = ((flags_reg & ~flag_clr) | flag_set) & diag_enable_i & diag_flags_pkg::FLAG_IMPL_MASK;

    // sticky flag register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_reg <= diag_flags_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // inverted copy of the dac code, reloaded with each new code
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            inv_copy_reg <= 16'hFFFF;
        end else if (dac_code_load_i) begin
            inv_copy_reg <= ~dac_code_i;
        end
    end

    // full results word with address echo
    // bit 10 is reserved and reads zero; without it every field above bit 10 would slip by one
    assign results_word = {2'b00, fault_pin_status_i, diag_flags_pkg::DIAG_RESULTS_ADDR,
        unrefreshed, slew_busy_i, upper_flags_i, 1'b0, flags_reg[9:8], 1'b0,
        flags_reg[6:4], 1'b0, flags_reg[2:0]};
    // only the results register is held here; other addresses read back as zero
    assign readback_word = (readback_addr_reg == diag_flags_pkg::DIAG_RESULTS_ADDR) ? results_word : 24'h00_0000;

    // two-stage readback: select in one frame, shift out in the next
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            readback_addr_reg <= diag_flags_pkg::DIAG_RESULTS_ADDR;
        end else if (readback_write) begin
            readback_addr_reg <= data[4:0];
        end
    end

    // readback register resets to the full word
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdo_shift_reg <= diag_flags_pkg::RESULTS_RESET;
        end else if (frame_start) begin
            sdo_shift_reg <= readback_word;
        end else if (fall_edge) begin
            sdo_shift_reg <= {sdo_shift_reg[22:0], 1'b0};
        end
    end

    // registered pin and status outputs
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdo_o <= 1'b0;
            flags_o <= diag_flags_pkg::FLAGS_RESET;
            write_strobe_o <= 1'b0;
            write_addr_o <= 5'h00;
            write_data_o <= 16'h0000;
        end else begin
            sdo_o <= sdo_shift_reg[23]; // msb first, one cycle behind the shifter
            flags_o <= flags_next;
            write_strobe_o <= write_ok && !clear_write && !readback_write;
            write_addr_o <= addr;
            write_data_o <= data;
        end
    end

endmodule : digital_diag_error_flags

// ---- tb/diag_flags_sva.sv ----
`timescale 1ns/1ps
// watches the flag and write outputs of the diagnostic flag block
module diag_flags_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // causes
    input wire logic sync_n_i,
    input wire logic [9:0] diag_enable_i,
    input wire logic interdie_parity_err_i,
    input wire logic [15:0] latch_in_i,
    input wire logic [15:0] latch_out_i,
    // effects
    input wire logic sdo_o,
    input wire logic [9:0] flags_o,
    input wire logic write_strobe_o,
    input wire logic [4:0] write_addr_o
);
    default clocking dcb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    // reset must hold the flags, write strobe and sdo quiet, so it is not disabled by reset
    reset_quiet_a: assert property (disable iff (1'b0) !nrst_i |-> flags_o == 10'h000 && !write_strobe_o && !sdo_o)
        else $error("outputs active in reset");
    reserved_zero_a: assert property (flags_o[7] == 1'b0 && flags_o[3] == 1'b0)
        else $error("reserved flag bit set");
    disabled_zero_a: assert property ((flags_o & ~$past(diag_enable_i)) == 10'h000)
        else $error("disabled flag reads one");
    interdie_set_a: assert property (interdie_parity_err_i && diag_enable_i[9] |=> flags_o[9])
        else $error("parity error not flagged");
    latch_set_a: assert property ((latch_in_i != latch_out_i) && diag_enable_i[8] |=> flags_o[8])
        else $error("latch mismatch not flagged");
    // a flag may only drop after a frame ends or its enable moves
    flag_sticky_a: assert property ((!sync_n_i && $stable(diag_enable_i))[*8] |-> (~flags_o & $past(flags_o)) == 10'h000)
        else $error("flag dropped inside a frame");
    frame_check_a: assert property (|(flags_o[2:0] & ~$past(flags_o[2:0])) |-> $past(sync_n_i, 3))
        else $error("frame flag set before release");
    write_legal_a: assert property (write_strobe_o |-> diag_flags_pkg::VALID_ADDR_MASK[write_addr_o]
        && !diag_flags_pkg::READ_ONLY_MASK[write_addr_o] && write_addr_o != diag_flags_pkg::DIAG_RESULTS_ADDR)
        else $error("write passed to illegal address");
    write_pulse_a: assert property (write_strobe_o |=> !write_strobe_o)
        else $error("write strobe longer than a cycle");

    // main scenarios reached
    cover property (flags_o[9]);
    cover property (write_strobe_o);
    cover property ($rose(flags_o[2]));
    cover property ($rose(flags_o[4]));
endmodule : diag_flags_sva

bind digital_diag_error_flags diag_flags_sva u_sva (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .sync_n_i(sync_n_i), .diag_enable_i(diag_enable_i),
    .interdie_parity_err_i(interdie_parity_err_i), .latch_in_i(latch_in_i), .latch_out_i(latch_out_i),
    .sdo_o(sdo_o), .flags_o(flags_o), .write_strobe_o(write_strobe_o), .write_addr_o(write_addr_o)
);

// ---- tb/serial_host_model.sv ----
`timescale 1ns/1ps
// serial host: idles clock high, shifts msb first on falling edges
module serial_host_model (
    // clock and readback pin
    input wire logic mclk_i,
    input wire logic sdo_i,
    // serial pins
    output logic sclk_o,
    output logic sync_n_o,
    output logic sdi_o
);
    // idle levels at time zero
    initial begin
        sclk_o = 1'b1;
        sync_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // four system clocks per level keeps each level seen after sync
    task automatic half_wait();
        repeat (4) @(posedge mclk_i);
        #2;
    endtask : half_wait

    task automatic xfer(input logic [23:0] w, input int n, input logic bad, output logic [23:0] rd);
        logic [7:0] c;
        logic [31:0] bits;
        c = 8'h00;
        rd = 24'h00_0000;
        for (int b = 23; b >= 0; b--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[b]) ? 8'h07 : 8'h00);
        bits = {w, c ^ {8{bad}}};
        half_wait();
        sync_n_o = 1'b0;
        // edge count as asked; slip bit as given
        for (int i = 0; i < n; i++) begin
            sdi_o = (i < 32) ? bits[31-i] : 1'b0;
            half_wait();
            sclk_o = 1'b0;
            half_wait();
            // read late in the low phase: the first bit only reaches the pin five cycles after select
            if (i < 24) rd[23-i] = sdo_i;
            sclk_o = 1'b1;
        end
        half_wait();
        sync_n_o = 1'b1;
        sdi_o = ~sdi_o; // released line no longer holds the last bit
        repeat (4) half_wait();
    endtask : xfer
endmodule : serial_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// self-checking bench for the diagnostic flag block
module tb_top;
    logic mclk_i, nrst_i, sclk_i, sync_n_i, sdi_i, sdo_o, crc_enable_i, interdie_parity_err_i;
    logic dac_code_load_i, refresh_start_i, cal_word_valid_i, refresh_done_i, write_strobe_o;
    logic [9:0] diag_enable_i, flags_o;
    logic [15:0] latch_in_i, latch_out_i, dac_code_i, cal_word_i, write_data_o, got_d;
    logic [7:0] cal_crc_i;
    logic [4:0] write_addr_o, got_a;
    logic [23:0] back;
    logic [31:0] seed;
    int n_fail, total_checks, n_strobe, cyc, expf, unref, busy, held;
    int cnts[8] = '{24, 32, 23, 25, 31, 32, 24, 31};
    logic [5:0] acc[6] = '{6'h06, 6'h0D, 6'h39, 6'h17, 6'h16, 6'h37};

    digital_diag_error_flags dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk_i), .sync_n_i(sync_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o),
        .diag_enable_i(diag_enable_i), .crc_enable_i(crc_enable_i), .fault_pin_status_i(1'b0),
        .slew_busy_i(1'b0), .upper_flags_i(3'h0), .interdie_parity_err_i(interdie_parity_err_i),
        .latch_in_i(latch_in_i), .latch_out_i(latch_out_i), .dac_code_load_i(dac_code_load_i),
        .dac_code_i(dac_code_i), .refresh_start_i(refresh_start_i), .cal_word_valid_i(cal_word_valid_i),
        .cal_word_i(cal_word_i), .refresh_done_i(refresh_done_i), .cal_crc_i(cal_crc_i), .flags_o(flags_o),
        .write_strobe_o(write_strobe_o), .write_addr_o(write_addr_o), .write_data_o(write_data_o)
    );
    serial_host_model host (.mclk_i(mclk_i), .sdo_i(sdo_o), .sclk_o(sclk_i), .sync_n_o(sync_n_i), .sdi_o(sdi_i));

    // 25 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // record accepted writes and cut a hang short
    always @(posedge mclk_i) begin
        cyc++;
        if (write_strobe_o === 1'b1) begin
            n_strobe++;
            got_a = write_addr_o;
            got_d = write_data_o;
        end
        if (cyc == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end

    function automatic logic [15:0] rnd16();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction : rnd16

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #2;
    endtask : tick

    task automatic fail(input string m);
        n_fail++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail

    // disabled flags are forced to zero, so the model forgets them too
    task automatic chk_flags();
        expf = (expf | held) & int'(diag_enable_i);
        total_checks++;
        if (flags_o !== 10'(expf)) fail("flags differ from model");
    endtask : chk_flags

    task automatic chk_wr(input logic ok, input int ns, input logic [4:0] a, input logic [15:0] d);
        total_checks++;
        if (ok ? (n_strobe != ns + 1 || got_a !== a || got_d !== d) : n_strobe != ns) fail("write strobe wrong");
    endtask : chk_wr

    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) fail("readback word wrong");
    endtask : chk_word

    task automatic frame(input logic rd, input logic [4:0] a, input logic [15:0] d, input int n, input logic bad,
                         input logic slip);
        logic [23:0] w;
        logic ok;
        int ns;
        w = {~rd ^ slip, rd, 1'b0, a, d};
        ns = n_strobe;
        ok = 1'b0;
        host.xfer(w, n, bad, back);
        if (crc_enable_i ? n != 32 : (n != 24 && n != 32)) expf = expf | 4;
        else if (slip) expf = expf | 2;
        else if (crc_enable_i && bad) expf = expf | 1;
        else if (rd) expf = expf | (diag_flags_pkg::VALID_ADDR_MASK[a] ? 0 : 16);
        else if (a == 5'h14) expf = expf & ~int'(d[9:0]);
        else if (a != 5'h13 && (!diag_flags_pkg::VALID_ADDR_MASK[a] || diag_flags_pkg::READ_ONLY_MASK[a]
                 || unref != 0 || busy != 0)) expf = expf | 16;
        else ok = (a != 5'h13);
        tick(12);
        chk_flags();
        chk_wr(ok, ns, a, d);
    endtask : frame

    task automatic clear_all();
        frame(1'b0, 5'h14, 16'h03FF, crc_enable_i ? 32 : 24, 1'b0, 1'b0);
    endtask : clear_all

    task automatic ref_start();
        refresh_start_i = 1'b1;
        tick(1);
        refresh_start_i = 1'b0;
        busy = 1;
    endtask : ref_start

    task automatic ref_finish(input logic bad);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 8; i++) begin
            cal_word_i = rnd16();
            for (int b = 15; b >= 0; b--) c = {c[6:0], 1'b0} ^ ((c[7] ^ cal_word_i[b]) ? 8'h07 : 8'h00);
            cal_word_valid_i = 1'b1;
            tick(1);
            cal_word_valid_i = 1'b0;
        end
        cal_crc_i = c ^ {8{bad}};
        refresh_done_i = 1'b1;
        tick(1);
        refresh_done_i = 1'b0;
        busy = 0;
        unref = 0;
        expf = expf | (bad ? 32 : 0);
        tick(4);
        chk_flags();
    endtask : ref_finish

    // raise one monitor event for a cycle, then reload the dac copy
    task automatic ev(input int k);
        case (k)
            9: interdie_parity_err_i = 1'b1;
            8: latch_out_i = ~latch_in_i;
            default: dac_code_i = dac_code_i ^ 16'h0001;
        endcase
        tick(1);
        interdie_parity_err_i = 1'b0;
        latch_out_i = latch_in_i;
        dac_code_load_i = 1'b1;
        tick(1);
        dac_code_load_i = 1'b0;
        expf = expf | (1 << k);
        tick(4);
        chk_flags();
    endtask : ev

    task automatic report_and_stop();
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // main sequence
    initial begin
        seed = 32'h0001_6903;
        nrst_i = 1'b0;
        diag_enable_i = 10'h3BF;
        {crc_enable_i, interdie_parity_err_i, dac_code_load_i} = 3'h0;
        {refresh_start_i, cal_word_valid_i, refresh_done_i} = 3'h0;
        {cal_word_i, latch_in_i, latch_out_i, dac_code_i, cal_crc_i} = 72'h00_0000_0000_0000_0000;
        unref = 1;
        tick(8);
        nrst_i = 1'b1;
        latch_in_i = rnd16();
        latch_out_i = latch_in_i;
        dac_code_i = rnd16();
        dac_code_load_i = 1'b1;
        tick(1);
        dac_code_load_i = 1'b0;
        diag_enable_i = 10'h3FF;
        tick(4);
        chk_flags();
        frame(1'b1, 5'h14, 16'h0000, 24, 1'b0, 1'b0);
        chk_word(back, 24'h14_8000);
        frame(1'b0, 5'h06, rnd16(), 24, 1'b0, 1'b0);
        ref_start();
        frame(1'b0, 5'h06, rnd16(), 24, 1'b0, 1'b0);
        frame(1'b0, 5'h13, 16'h0014, 24, 1'b0, 1'b0);
        ref_finish(1'b0);
        ref_start();
        ref_finish(1'b1);
        frame(1'b0, 5'h14, 16'h0000, 24, 1'b0, 1'b0);
        clear_all();
        for (int i = 0; i < 6; i++) begin
            frame(acc[i][5], acc[i][4:0], rnd16(), 24, 1'b0, 1'b0);
            clear_all();
        end
        for (int i = 0; i < 8; i++) begin
            crc_enable_i = (i >= 5);
            diag_enable_i = (i >= 5 && cnts[i] != 32) ? 10'h004 : 10'h3FF;
            frame(1'b1, 5'h14, 16'h0000, cnts[i], 1'b0, 1'b0);
            diag_enable_i = 10'h3FF;
            clear_all();
        end
        frame(1'b1, 5'h14, 16'h0000, 32, 1'b1, 1'b0);
        clear_all();
        crc_enable_i = 1'b0;
        frame(1'b1, 5'h14, 16'h0000, 24, 1'b0, 1'b1);
        ev(9);
        ev(8);
        ev(6);
        clear_all();
        diag_enable_i = 10'h1FF;
        ev(9);
        diag_enable_i = 10'h3FF;
        held = 512;
        interdie_parity_err_i = 1'b1;
        frame(1'b0, 5'h14, 16'h0200, 24, 1'b0, 1'b0);
        interdie_parity_err_i = 1'b0;
        held = 0;
        ev(8);
        frame(1'b0, 5'h13, 16'h0014, 24, 1'b0, 1'b0);
        frame(1'b1, 5'h14, 16'h0000, 24, 1'b0, 1'b0);
        chk_word(back, 24'h14_0000 | 24'(expf));
        report_and_stop();
    end
endmodule : tb_top
